/* File: core/scirq_defines.svh */
// register offsets, field positions, reset values and masks of the interrupt enable block
`ifndef SCIRQ_DEFINES_SVH
`define SCIRQ_DEFINES_SVH

`define SCIRQ_ADDR_W 8
`define SCIRQ_DATA_W 32
`define SCIRQ_NSRC 18

`define SCIRQ_OFS_ENCLR 8'h00
`define SCIRQ_OFS_ENSET 8'h04
`define SCIRQ_OFS_FLAG 8'h08
`define SCIRQ_OFS_LOCK 8'h0c

`define SCIRQ_EN_RESET 32'h00000000
`define SCIRQ_FLAG_RESET 32'h00000000
`define SCIRQ_LOCK_RESET 1'h0
`define SCIRQ_IMPL_MASK 32'h00038fff

`define SCIRQ_BIT_XTAL_RDY 0
`define SCIRQ_BIT_XTAL32K_RDY 1
`define SCIRQ_BIT_RC32K_RDY 2
`define SCIRQ_BIT_RC8M_RDY 3
`define SCIRQ_BIT_FLL_RDY 4
`define SCIRQ_BIT_FLL_OOB 5
`define SCIRQ_BIT_FLL_FINE 6
`define SCIRQ_BIT_FLL_COARSE 7
`define SCIRQ_BIT_FLL_REFSTOP 8
`define SCIRQ_BIT_BOD_RDY 9
`define SCIRQ_BIT_BOD_DET 10
`define SCIRQ_BIT_BOD_SYNC 11
`define SCIRQ_BIT_PLL_GAINED 15
`define SCIRQ_BIT_PLL_LOST 16
`define SCIRQ_BIT_PLL_TIMEOUT 17

`define SCIRQ_BIT_LOCK 0

`endif

/* File: core/scirq_pkg.sv */
// types shared by the interrupt enable block
`include "scirq_defines.svh"

package scirq_pkg;

    typedef enum logic [1:0] {
        SCIRQ_IDLE = 2'h1,
        SCIRQ_RESP = 2'h2
    } scirq_bus_state_t;

    typedef struct packed {
        scirq_bus_state_t busState;
        logic ack;
        logic [`SCIRQ_DATA_W-1:0] rdData;
        logic [`SCIRQ_NSRC-1:0] flagSnap;
        logic lock;
        logic [`SCIRQ_NSRC-1:0] req;
        logic irq;
    } scirq_top_state_t;

    typedef struct packed {
        logic en;
    } scirq_en_state_t;

    typedef struct packed {
        logic flag;
    } scirq_flag_state_t;

endpackage

/* File: core/scirq_enable_cell.sv */
// one interrupt enable bit driven by separate set and clear strobes
`timescale 1ns/1ps
`default_nettype none

module scirq_enable_cell (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic setStb,
    input wire logic clrStb,
    output logic enOut
);

    scirq_pkg::scirq_en_state_t st_reg;
    scirq_pkg::scirq_en_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // RULE1 zero keeps enable
        if (setStb) begin
            st_next.en = 1'b1;
        end else if (clrStb) begin
            st_next.en = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{en: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign enOut = st_reg.en;

endmodule

`default_nettype wire

/* File: core/scirq_flag_cell.sv */
// one sticky interrupt flag: an event sets it, a committed read clears it
`timescale 1ns/1ps
`default_nettype none

module scirq_flag_cell (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic eventIn,
    input wire logic clrStb,
    output logic flagOut
);

    scirq_pkg::scirq_flag_state_t st_reg;
    scirq_pkg::scirq_flag_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // an event in the clearing cycle wins so it is never lost
        if (eventIn) begin
            st_next.flag = 1'b1;
        end else if (clrStb) begin
            st_next.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{flag: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign flagOut = st_reg.flag;

endmodule

`default_nettype wire

/* File: core/scirq_ctrl.sv */
// interrupt enable set/clear register pair with sticky flags behind a classic wishbone slave
// Behaviour
// RULE1: writing a zero to any enable bit in the set or clear register leaves that enable as it was.
// RULE2: a one written to bits 3..0 of the clear register clears the 8 MHz, 32 kHz, external 32 kHz or crystal ready enable.
// RULE3: the set register resets to zero and a write while write protection is on changes nothing.
// RULE4: a one written to bit 17 of the set register sets the pll lock-timeout enable.
// RULE5: a one written to bit 16 of the set register sets the pll lock-lost enable.
// RULE6: a one written to bit 15 of the set register sets the pll lock-gained enable.
// RULE7: a one written to bit 11 of the set register sets the brown-out sync-ready enable.
// RULE8: a one written to bit 10 of the set register sets the brown-out detect enable.
// RULE9: a source requests an interrupt whenever its enable is one and its flag is set, and never with enable zero.
// RULE10: bits 9..0 of the set register hold the remaining enables, brown-out ready down to crystal ready.
// RULE11: a one written to bit 15 or bits 11..8 of the clear register clears the matching enable.
// RULE12: both registers read back the live enables, with bits 31..18 and 14..12 reading zero and ignoring writes.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "scirq_defines.svh"

module scirq_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SCIRQ_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`SCIRQ_DATA_W-1:0] wb_dat_i,
    output logic [`SCIRQ_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`SCIRQ_NSRC-1:0] srcEvent,
    output logic [`SCIRQ_NSRC-1:0] irqReq,
    output logic irq,
    output logic wpLocked
);

    scirq_pkg::scirq_top_state_t st_reg;
    scirq_pkg::scirq_top_state_t st_next;

    // live state of the per-source cells
    logic [`SCIRQ_DATA_W-1:0] enVec;
    wire logic [`SCIRQ_DATA_W-1:0] flagVec;

    // named enables, one cell each
    logic pll_lock_timeout_en;
    logic pll_lock_lost_en;
    logic pll_lock_gained_en;
    logic brownout_sync_ready_en;
    logic brownout_detect_en;
    logic brownout_ready_en;
    logic fll_ref_stopped_en;
    logic fll_coarse_lock_en;
    logic fll_fine_lock_en;
    logic fll_out_of_bounds_en;
    logic fll_ready_en;
    logic rc8m_ready_en;
    logic rc32k_ready_en;
    logic xtal32k_ready_en;
    logic xtal_ready_en;

    // per-source set/clear/flag-clear strobes, valid only in the commit cycle, and the masked event inputs
    logic [`SCIRQ_DATA_W-1:0] setStb;
    logic [`SCIRQ_DATA_W-1:0] clrStb;
    logic [`SCIRQ_DATA_W-1:0] flagClr;
    logic [`SCIRQ_DATA_W-1:0] eventVec;

    // decode of the bus request
    logic [`SCIRQ_ADDR_W-1:0] wordAddr;
    logic busReq;
    logic hitClr;
    logic hitSet;
    logic hitFlag;
    logic hitLock;
    logic commit;
    logic [`SCIRQ_DATA_W-1:0] laneMask;
    logic [`SCIRQ_DATA_W-1:0] wrBits;
    logic [`SCIRQ_DATA_W-1:0] rdMux;
    logic enWrAllowed;

    localparam logic [`SCIRQ_DATA_W-1:0] IMPL_MASK = `SCIRQ_IMPL_MASK;

    assign wordAddr = {wb_adr_i[`SCIRQ_ADDR_W-1:2], 2'h0};
    assign busReq = wb_cyc_i && wb_stb_i;
    assign hitClr = (wordAddr == `SCIRQ_OFS_ENCLR);
    assign hitSet = (wordAddr == `SCIRQ_OFS_ENSET);
    assign hitFlag = (wordAddr == `SCIRQ_OFS_FLAG);
    assign hitLock = (wordAddr == `SCIRQ_OFS_LOCK);

    // the edge that samples ack high is the one at which a write lands
    assign commit = (st_reg.busState == scirq_pkg::SCIRQ_RESP) && st_reg.ack && busReq;

    assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // RULE12 reserved bits ignore writes
    assign wrBits = wb_dat_i & laneMask & IMPL_MASK;

    // RULE3 protection blocks enable writes
    assign enWrAllowed = commit && wb_we_i && !st_reg.lock;

    // RULE1 only ones produce strobes
    // RULE4 set strobes per bit
    // RULE10 low enables share the same path
    assign setStb = (enWrAllowed && hitSet) ? wrBits : `SCIRQ_EN_RESET;

    // RULE2 clear strobes per bit
    // RULE11 upper bits clear as well
    assign clrStb = (enWrAllowed && hitClr) ? wrBits : `SCIRQ_EN_RESET;

    // only the flags the read really returned are cleared, later events survive
    assign flagClr = (commit && !wb_we_i && hitFlag) ?
        {{(`SCIRQ_DATA_W-`SCIRQ_NSRC){1'b0}}, st_reg.flagSnap} : `SCIRQ_FLAG_RESET;

    assign eventVec = {{(`SCIRQ_DATA_W-`SCIRQ_NSRC){1'b0}}, srcEvent} & IMPL_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < `SCIRQ_DATA_W; gi = gi + 1) begin : g_src
            if (IMPL_MASK[gi]) begin : g_impl
                scirq_flag_cell u_flag (
                    .mclk(mclk),
                    .rst_n(rst_n),
                    .eventIn(eventVec[gi]),
                    .clrStb(flagClr[gi]),
                    .flagOut(flagVec[gi])
                );
            end else begin : g_rsvd
                // RULE12 reserved bits read zero
                assign flagVec[gi] = 1'b0;
            end
        end
    endgenerate

    // RULE10 enable word layout
    always_comb begin
        enVec = `SCIRQ_EN_RESET;
        enVec[`SCIRQ_BIT_PLL_TIMEOUT] = pll_lock_timeout_en;
        enVec[`SCIRQ_BIT_PLL_LOST] = pll_lock_lost_en;
        enVec[`SCIRQ_BIT_PLL_GAINED] = pll_lock_gained_en;
        enVec[`SCIRQ_BIT_BOD_SYNC] = brownout_sync_ready_en;
        enVec[`SCIRQ_BIT_BOD_DET] = brownout_detect_en;
        enVec[`SCIRQ_BIT_BOD_RDY] = brownout_ready_en;
        enVec[`SCIRQ_BIT_FLL_REFSTOP] = fll_ref_stopped_en;
        enVec[`SCIRQ_BIT_FLL_COARSE] = fll_coarse_lock_en;
        enVec[`SCIRQ_BIT_FLL_FINE] = fll_fine_lock_en;
        enVec[`SCIRQ_BIT_FLL_OOB] = fll_out_of_bounds_en;
        enVec[`SCIRQ_BIT_FLL_RDY] = fll_ready_en;
        enVec[`SCIRQ_BIT_RC8M_RDY] = rc8m_ready_en;
        enVec[`SCIRQ_BIT_RC32K_RDY] = rc32k_ready_en;
        enVec[`SCIRQ_BIT_XTAL32K_RDY] = xtal32k_ready_en;
        enVec[`SCIRQ_BIT_XTAL_RDY] = xtal_ready_en;
    end

    // one cell per source keeps each enable traceable to its bit
    // RULE4 lock-timeout cell
    scirq_enable_cell u_pll_lock_timeout (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_PLL_TIMEOUT]),
        .clrStb(clrStb[`SCIRQ_BIT_PLL_TIMEOUT]),
        .enOut(pll_lock_timeout_en)
    );
    // RULE5 lock-lost cell
    scirq_enable_cell u_pll_lock_lost (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_PLL_LOST]),
        .clrStb(clrStb[`SCIRQ_BIT_PLL_LOST]),
        .enOut(pll_lock_lost_en)
    );
    // RULE6 lock-gained cell
    scirq_enable_cell u_pll_lock_gained (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_PLL_GAINED]),
        .clrStb(clrStb[`SCIRQ_BIT_PLL_GAINED]),
        .enOut(pll_lock_gained_en)
    );
    // RULE7 sync-ready cell
    scirq_enable_cell u_brownout_sync_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_BOD_SYNC]),
        .clrStb(clrStb[`SCIRQ_BIT_BOD_SYNC]),
        .enOut(brownout_sync_ready_en)
    );
    // RULE8 detect cell
    scirq_enable_cell u_brownout_detect (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_BOD_DET]),
        .clrStb(clrStb[`SCIRQ_BIT_BOD_DET]),
        .enOut(brownout_detect_en)
    );
    // RULE10 brown-out ready cell
    scirq_enable_cell u_brownout_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_BOD_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_BOD_RDY]),
        .enOut(brownout_ready_en)
    );
    // RULE10 reference-stopped cell
    scirq_enable_cell u_fll_ref_stopped (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_FLL_REFSTOP]),
        .clrStb(clrStb[`SCIRQ_BIT_FLL_REFSTOP]),
        .enOut(fll_ref_stopped_en)
    );
    // RULE10 coarse lock cell
    scirq_enable_cell u_fll_coarse_lock (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_FLL_COARSE]),
        .clrStb(clrStb[`SCIRQ_BIT_FLL_COARSE]),
        .enOut(fll_coarse_lock_en)
    );
    // RULE10 fine lock cell
    scirq_enable_cell u_fll_fine_lock (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_FLL_FINE]),
        .clrStb(clrStb[`SCIRQ_BIT_FLL_FINE]),
        .enOut(fll_fine_lock_en)
    );
    // RULE10 out-of-bounds cell
    scirq_enable_cell u_fll_out_of_bounds (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_FLL_OOB]),
        .clrStb(clrStb[`SCIRQ_BIT_FLL_OOB]),
        .enOut(fll_out_of_bounds_en)
    );
    // RULE10 fll ready cell
    scirq_enable_cell u_fll_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_FLL_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_FLL_RDY]),
        .enOut(fll_ready_en)
    );
    // RULE2 8 MHz cell
    scirq_enable_cell u_rc8m_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_RC8M_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_RC8M_RDY]),
        .enOut(rc8m_ready_en)
    );
    // RULE2 32 kHz cell
    scirq_enable_cell u_rc32k_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_RC32K_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_RC32K_RDY]),
        .enOut(rc32k_ready_en)
    );
    // RULE2 crystal 32 kHz cell
    scirq_enable_cell u_xtal32k_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_XTAL32K_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_XTAL32K_RDY]),
        .enOut(xtal32k_ready_en)
    );
    // RULE2 crystal ready cell
    scirq_enable_cell u_xtal_ready (
        .mclk(mclk),
        .rst_n(rst_n),
        .setStb(setStb[`SCIRQ_BIT_XTAL_RDY]),
        .clrStb(clrStb[`SCIRQ_BIT_XTAL_RDY]),
        .enOut(xtal_ready_en)
    );

    // read data selection, taken when the request is first seen
    always_comb begin
        rdMux = `SCIRQ_EN_RESET;
        case (1'b1)
            // RULE12 both registers show live enables
            hitClr: begin
                rdMux = enVec;
            end
            hitSet: begin
                rdMux = enVec;
            end
            hitFlag: begin
                rdMux = flagVec;
            end
            hitLock: begin
                rdMux[`SCIRQ_BIT_LOCK] = st_reg.lock;
            end
            default: begin
                rdMux = `SCIRQ_EN_RESET;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;

        // RULE9 request is enable and flag
        st_next.req = enVec[`SCIRQ_NSRC-1:0] & flagVec[`SCIRQ_NSRC-1:0];
        // RULE9 enable zero masks the source
        st_next.irq = |(enVec[`SCIRQ_NSRC-1:0] & flagVec[`SCIRQ_NSRC-1:0]);

        case (st_reg.busState)
            scirq_pkg::SCIRQ_IDLE: begin
                st_next.ack = 1'b0;
                if (busReq && !st_reg.ack) begin
                    st_next.busState = scirq_pkg::SCIRQ_RESP;
                    st_next.ack = 1'b1;
                    // unmapped addresses answer with zero and take no write
                    st_next.rdData = wb_we_i ? `SCIRQ_EN_RESET : rdMux;
                    st_next.flagSnap = (wb_we_i || !hitFlag) ? {`SCIRQ_NSRC{1'b0}} : flagVec[`SCIRQ_NSRC-1:0];
                end
            end
            scirq_pkg::SCIRQ_RESP: begin
                // one-cycle ack; the master releases right after it
                st_next.ack = 1'b0;
                st_next.busState = scirq_pkg::SCIRQ_IDLE;
                st_next.flagSnap = {`SCIRQ_NSRC{1'b0}};
                // the lock register stays writable so software can lift protection
                if (commit && wb_we_i && hitLock && wb_sel_i[0]) begin
                    st_next.lock = wb_dat_i[`SCIRQ_BIT_LOCK];
                end
            end
            default: begin
                st_next.busState = scirq_pkg::SCIRQ_IDLE;
                st_next.ack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{busState: scirq_pkg::SCIRQ_IDLE,
                        ack: 1'b0,
                        rdData: `SCIRQ_EN_RESET,
                        flagSnap: {`SCIRQ_NSRC{1'b0}},
                        lock: `SCIRQ_LOCK_RESET,
                        req: {`SCIRQ_NSRC{1'b0}},
                        irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdData;
    assign irqReq = st_reg.req;
    assign irq = st_reg.irq;
    assign wpLocked = st_reg.lock;

endmodule

`default_nettype wire

/* File: verif/scirq_ctrl_monitor.sv */
// concurrent checks on the ports of the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "scirq_defines.svh"
module scirq_ctrl_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SCIRQ_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`SCIRQ_DATA_W-1:0] wb_dat_i,
    input wire logic [`SCIRQ_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [`SCIRQ_NSRC-1:0] srcEvent,
    input wire logic [`SCIRQ_NSRC-1:0] irqReq,
    input wire logic irq,
    input wire logic wpLocked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // full-lane write at the edge where ack is sampled
    logic wrDone;
    assign wrDone = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i == 4'hf;
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_prompt_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("no ack");
    irq_any_a: assert property (irq == (|irqReq)) else $error("irq not OR of requests");
    resv_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:3] == 5'h0
        |-> (wb_dat_o & ~`SCIRQ_IMPL_MASK) == 32'h0) else $error("reserved bit set");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h0
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    clr_all_a: assert property (wrDone && wb_adr_i[7:2] == 6'h0 && wb_dat_i == 32'hffffffff && !wpLocked
        |-> ##2 irqReq == 18'h0) else $error("clear left a request");
    // after a zero clear write, requests only grow while no flag read lands
    clr_zero_a: assert property (wrDone && wb_adr_i[7:2] == 6'h0 && wb_dat_i == 32'h0
        |-> ##2 (irqReq & $past(irqReq, 2)) == $past(irqReq, 2)) else $error("zero write cleared");
    locked_hold_a: assert property (wrDone && wb_adr_i[7:3] == 5'h0 && wpLocked
        |-> ##2 (irqReq & $past(irqReq, 2)) == $past(irqReq, 2)) else $error("locked write acted");
    lock_track_a: assert property (wrDone && wb_adr_i[7:2] == 6'h3
        |=> wpLocked == $past(wb_dat_i[0])) else $error("lock state wrong");
    cover property (wrDone && wpLocked);
    cover property (irq);
    cover property ($fell(irq));
endmodule
bind scirq_ctrl scirq_ctrl_monitor mon (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .srcEvent(srcEvent), .irqReq(irqReq), .irq(irq), .wpLocked(wpLocked));
`default_nettype wire

/* File: verif/scirq_ctrl_tb.sv */
// self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "scirq_defines.svh"
module scirq_ctrl_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [17:0] ev = 18'h0;
    logic [31:0] rdat, en, m;
    logic [31:0] seed = 32'h38ad;
    logic [17:0] req;
    logic ack, irq, wpLocked;
    logic [31:0] expQ[$];
    int mismatches = 0;
    int checked = 0;
    always #5 mclk = ~mclk;
    scirq_ctrl uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .srcEvent(ev), .irqReq(req), .irq(irq),
        .wpLocked(wpLocked));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // the wait has no limit of its own: the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'hf, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 4'hf, 32'h0);
    endtask
    // read data taken at the edge where ack is sampled
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (expQ.size() == 0) cmp("unsolicited read", 32'h1, 32'h0);
            else cmp("read data", expQ.pop_front(), rdat);
        end
    end
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        for (int b = 0; b < 32; b++) begin
            wr(8'h04, 32'h1 << b);
            rd(8'h00, (32'h1 << b) & `SCIRQ_IMPL_MASK);
            wr(8'h00, 32'h1 << b);
            rd(8'h04, 32'h0);
        end
        ev <= 18'h38fff;
        @(posedge mclk);
        ev <= 18'h0;
        repeat (3) @(posedge mclk);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(8'h04, 32'h400);
        wr(8'h00, 32'h0);
        cmp("irqReq", 32'h400, {14'h0, req});
        cmp("irq", 32'h1, {31'h0, irq});
        wr(8'h0c, 32'h1);
        cmp("wpLocked", 32'h1, {31'h0, wpLocked});
        wr(8'h00, 32'hffffffff);
        rd(8'h04, 32'h400);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'hffffffff);
        repeat (2) @(posedge mclk);
        cmp("irq", 32'h0, {31'h0, irq});
        rd(8'h08, 32'h00038fff);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'hffffffff);
        ev <= 18'h38fff;
        @(posedge mclk);
        ev <= 18'h0;
        repeat (2) @(posedge mclk);
        cmp("irqReq", 32'h00038fff, {14'h0, req});
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        cmp("irqReq", 32'h0, {14'h0, req});
        rd(8'h04, 32'h0);
        en = 32'h0;
        for (int i = 0; i < 64; i++) begin
            seed = lfsr(seed);
            m = {{8{seed[31]}}, {8{seed[30]}}, {8{seed[29]}}, {8{seed[28]}}} & seed & `SCIRQ_IMPL_MASK;
            en = i[0] ? (en & ~m) : (en | m);
            bus(1'b1, {5'h0, ~i[0], 2'h0}, seed[31:28], seed);
            rd(8'h04, en);
        end
        cmp("pending reads", 32'h0, expQ.size());
        give_verdict();
    end
endmodule
`default_nettype wire
